// [rtl/e1_fas_pkg.sv]
// shared constants and types for the e1 fas alignment search
package e1_fas_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] CTRL_INDEX      = 10'h107;
    localparam logic [9:0] STATUS_INDEX    = 10'h108;
    localparam logic [9:0] IRQ_STAT_INDEX  = 10'h109;
    localparam logic [9:0] IRQ_CLEAR_INDEX = 10'h10a;
    localparam logic [9:0] IRQ_EN_INDEX    = 10'h10b;

    // control register fields
    localparam int CTRL_METHOD_BIT  = 0;
    localparam int CTRL_EXTRA_BIT   = 1;
    localparam int CTRL_RESTART_BIT = 2;

    // interrupt status fields
    localparam int IRQ_SYNC_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam int IRQ_WIDTH    = 2;

    // reset values
    localparam logic       METHOD_RESET = 1'b0;
    localparam logic       EXTRA_RESET  = 1'b0;
    localparam logic [1:0] IRQ_EN_RESET = 2'h0;

    // frame structure: 256 bits per frame, 7-bit alignment pattern in ts0 bits 2..8
    localparam int         FRAME_BITS    = 256;
    localparam int         CNT_WIDTH     = 8;
    localparam logic [6:0] FAS_PATTERN   = 7'h1b;
    localparam int         NFAS_BIT_POS  = 6;

    typedef enum logic [2:0] {
        HUNT,
        NFAS_CHECK,
        FAS_CHECK,
        HOLDOFF,
        EXTRA_NFAS,
        EXTRA_FAS,
        SYNCED
    } search_state_type;

endpackage

// [rtl/e1_frame_if.sv]
// link between the alignment search and its frame position timer
`timescale 1ns/1ps
interface e1_frame_if;
    logic       lineBit;
    logic       lineValid;
    logic       realign;
    logic [7:0] pattern;
    logic       shifted;
    logic       frameMark;

    modport timer (
        input  lineBit,
        input  lineValid,
        input  realign,
        output pattern,
        output shifted,
        output frameMark
    );

    modport search (
        output lineBit,
        output lineValid,
        output realign,
        input  pattern,
        input  shifted,
        input  frameMark
    );
endinterface

// [rtl/e1_frame_timer.sv]
// ts0 shift window and bit position counter for the receive stream
`timescale 1ns/1ps
module e1_frame_timer (
    // clock and reset
    input wire logic    clk,
    input wire logic    rst_n,
    // link to the search logic
    e1_frame_if.timer   link
);
    logic [e1_fas_pkg::CNT_WIDTH-1:0] bitCount;

    // the wrap of the bit counter is the frame boundary, so the two must agree
    if (e1_fas_pkg::FRAME_BITS != (1 << e1_fas_pkg::CNT_WIDTH)) begin : g_badLength
        $error("frame length must equal the counter range");
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.pattern <= 8'h00;
            link.shifted <= 1'b0;
        end else begin
            link.shifted <= link.lineValid;
            if (link.lineValid) begin
                link.pattern <= {link.pattern[6:0], link.lineBit};
            end
        end
    end

    // realign marks the bit just shifted in as the end of ts0
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitCount <= '0;
        end else if (link.realign) begin
            bitCount <= link.lineValid ? 8'h01 : 8'h00;
        end else if (link.lineValid) begin
            bitCount <= bitCount + 8'h01;
        end
    end

    // a whole frame after the anchor the window again holds an assumed ts0
    assign link.frameMark = link.shifted && (bitCount == 8'h00) && !link.realign;
endmodule

// [rtl/e1_fas_alignment_search.sv]
// e1 receive frame alignment signal search with wishbone registers
`timescale 1ns/1ps

// What this block does
// - A control bit resetting to 0 picks the search method: 0 the plain method, 1 the one with a hold-off.
// - Step one scans every received bit for the 7-bit alignment pattern and moves to step two on a hit.
// - Step two needs bit 2 of the next frame's assumed timeslot 0 to be one; under the plain method a miss restarts step one.
// - Step three needs the alignment pattern in the third frame's assumed timeslot 0, otherwise the search restarts at step one.
// - With the extra check bit clear, passing all three steps declares frame sync at once.
// - With the extra check bit set, two more frames must show correct alignment before sync is declared.
// - Under the hold-off method a failed step two goes to step four rather than straight to step one.
// - Step four waits one frame, to the next assumed alignment position, and then restarts step one.
// - Under the hold-off method a passing step three goes on to the optional extra check and a failing one restarts step one.
module e1_fas_alignment_search (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // receive stream from the line interface, one bit per valid strobe
    input  wire logic        rxData,
    input  wire logic        rxValid,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [11:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatIn,
    output logic      [31:0] wbDatOut,
    output logic             wbAck,
    // status outputs
    output logic             frameSync,
    output logic             irq
);
    e1_frame_if frameLink ();

    e1_fas_pkg::search_state_type state;
    logic                         methodSel;
    logic                         extraCheck;
    logic                         activeMethod;
    logic                         restartReq;
    logic [e1_fas_pkg::IRQ_WIDTH-1:0] irqStatus;
    logic [e1_fas_pkg::IRQ_WIDTH-1:0] irqEnable;
    logic                         wbReq;
    logic                         wbWrite;
    logic [9:0]                   wordIndex;
    logic                         fasHit;
    logic                         nfasOk;
    logic                         syncEvent;
    logic                         failEvent;

    e1_frame_timer timer (
        .clk   (clk),
        .rst_n (rst_n),
        .link  (frameLink)
    );

    assign frameLink.lineBit   = rxData;
    assign frameLink.lineValid = rxValid;
    assign fasHit = frameLink.pattern[6:0] == e1_fas_pkg::FAS_PATTERN;
    assign nfasOk = frameLink.pattern[e1_fas_pkg::NFAS_BIT_POS];

    // bus decode; ack one cycle after the request, dropped the cycle after
    assign wbReq     = wbCyc && wbStb && !wbAck;
    assign wbWrite   = wbReq && wbWe && wbSel[0];
    assign wordIndex = wbAdr[11:2];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= wbReq;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wbDatOut <= 32'h0000_0000;
        end else if (wbReq && !wbWe) begin
            unique case (wordIndex)
                e1_fas_pkg::CTRL_INDEX:     wbDatOut <= {30'h0, extraCheck, methodSel};
                e1_fas_pkg::STATUS_INDEX:   wbDatOut <= {28'h0, 3'(state), frameSync};
                e1_fas_pkg::IRQ_STAT_INDEX: wbDatOut <= {30'h0, irqStatus};
                e1_fas_pkg::IRQ_EN_INDEX:   wbDatOut <= {30'h0, irqEnable};
                default:                    wbDatOut <= 32'h0000_0000;
            endcase
        end
    end

    // control register; restart is a self-clearing strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            methodSel  <= e1_fas_pkg::METHOD_RESET;
            extraCheck <= e1_fas_pkg::EXTRA_RESET;
            restartReq <= 1'b0;
        end else begin
            restartReq <= 1'b0;
            if (wbWrite && wordIndex == e1_fas_pkg::CTRL_INDEX) begin
                methodSel  <= wbDatIn[e1_fas_pkg::CTRL_METHOD_BIT];
                extraCheck <= wbDatIn[e1_fas_pkg::CTRL_EXTRA_BIT];
                restartReq <= wbDatIn[e1_fas_pkg::CTRL_RESTART_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqEnable <= e1_fas_pkg::IRQ_EN_RESET;
        end else if (wbWrite && wordIndex == e1_fas_pkg::IRQ_EN_INDEX) begin
            irqEnable <= wbDatIn[e1_fas_pkg::IRQ_WIDTH-1:0];
        end
    end

    // search sequencer
    always_comb begin
        frameLink.realign = 1'b0;
        syncEvent = 1'b0;
        failEvent = 1'b0;
        if (!restartReq) begin
            unique case (state)
                e1_fas_pkg::HUNT: frameLink.realign = frameLink.shifted && fasHit;
                e1_fas_pkg::NFAS_CHECK: failEvent = frameLink.frameMark && !nfasOk;
                e1_fas_pkg::FAS_CHECK: begin
                    failEvent = frameLink.frameMark && !fasHit;
                    syncEvent = frameLink.frameMark && fasHit && !extraCheck;
                end
                e1_fas_pkg::EXTRA_NFAS: failEvent = frameLink.frameMark && !nfasOk;
                e1_fas_pkg::EXTRA_FAS: begin
                    failEvent = frameLink.frameMark && !fasHit;
                    syncEvent = frameLink.frameMark && fasHit;
                end
                e1_fas_pkg::HOLDOFF, e1_fas_pkg::SYNCED: begin
                end
            endcase
        end
    end

    // the method is latched when a search starts so a change cannot split one attempt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activeMethod <= e1_fas_pkg::METHOD_RESET;
        end else if (frameLink.realign) begin
            activeMethod <= methodSel;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= e1_fas_pkg::HUNT;
        end else if (restartReq) begin
            state <= e1_fas_pkg::HUNT;
        end else begin
            unique case (state)
                e1_fas_pkg::HUNT: begin
                    if (frameLink.realign) begin
                        state <= e1_fas_pkg::NFAS_CHECK;
                    end
                end
                e1_fas_pkg::NFAS_CHECK: begin
                    if (frameLink.frameMark) begin
                        if (nfasOk) begin
                            state <= e1_fas_pkg::FAS_CHECK;
                        end else if (activeMethod) begin
                            state <= e1_fas_pkg::HOLDOFF;
                        end else begin
                            state <= e1_fas_pkg::HUNT;
                        end
                    end
                end
                e1_fas_pkg::FAS_CHECK: begin
                    if (frameLink.frameMark) begin
                        if (!fasHit) begin
                            state <= e1_fas_pkg::HUNT;
                        end else if (extraCheck) begin
                            state <= e1_fas_pkg::EXTRA_NFAS;
                        end else begin
                            state <= e1_fas_pkg::SYNCED;
                        end
                    end
                end
                e1_fas_pkg::HOLDOFF: begin
                    if (frameLink.frameMark) begin
                        state <= e1_fas_pkg::HUNT;
                    end
                end
                e1_fas_pkg::EXTRA_NFAS: begin
                    if (frameLink.frameMark) begin
                        state <= nfasOk ? e1_fas_pkg::EXTRA_FAS : e1_fas_pkg::HUNT;
                    end
                end
                e1_fas_pkg::EXTRA_FAS: begin
                    if (frameLink.frameMark) begin
                        state <= fasHit ? e1_fas_pkg::SYNCED : e1_fas_pkg::HUNT;
                    end
                end
                e1_fas_pkg::SYNCED: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frameSync <= 1'b0;
        end else begin
            frameSync <= state == e1_fas_pkg::SYNCED;
        end
    end

    // sticky events; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStatus <= '0;
        end else begin
            if (wbWrite && wordIndex == e1_fas_pkg::IRQ_CLEAR_INDEX) begin
                irqStatus <= irqStatus & ~wbDatIn[e1_fas_pkg::IRQ_WIDTH-1:0]
                             | {failEvent, syncEvent};
            end else begin
                irqStatus <= irqStatus | {failEvent, syncEvent};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_resetHunt;
        $rose(rst_n) |-> state == e1_fas_pkg::HUNT && !frameSync;
    endproperty
    a_resetHunt: assert property (p_resetHunt) else $error("not hunting after reset");

    property p_huntHit;
        state == e1_fas_pkg::HUNT && frameLink.shifted && fasHit && !restartReq
            |=> state == e1_fas_pkg::NFAS_CHECK;
    endproperty
    a_huntHit: assert property (p_huntHit) else $error("pattern hit did not start check");

    property p_nfasFailPlain;
        state == e1_fas_pkg::NFAS_CHECK && frameLink.frameMark && !nfasOk && !activeMethod
            && !restartReq |=> state == e1_fas_pkg::HUNT;
    endproperty
    a_nfasFailPlain: assert property (p_nfasFailPlain) else $error("step two miss kept going");

    property p_fasFail;
        state == e1_fas_pkg::FAS_CHECK && frameLink.frameMark && !fasHit && !restartReq
            |=> state == e1_fas_pkg::HUNT ##1 !frameSync;
    endproperty
    a_fasFail: assert property (p_fasFail) else $error("step three miss kept going");

    property p_syncPlain;
        state == e1_fas_pkg::FAS_CHECK && frameLink.frameMark && fasHit && !extraCheck
            && !restartReq |=> state == e1_fas_pkg::SYNCED ##1 frameSync;
    endproperty
    a_syncPlain: assert property (p_syncPlain) else $error("sync not declared");

    property p_extraPath;
        state == e1_fas_pkg::FAS_CHECK && frameLink.frameMark && fasHit && extraCheck
            && !restartReq |=> state == e1_fas_pkg::EXTRA_NFAS ##1 !frameSync;
    endproperty
    a_extraPath: assert property (p_extraPath) else $error("extra check skipped");

    property p_holdoffEntry;
        state == e1_fas_pkg::NFAS_CHECK && frameLink.frameMark && !nfasOk && activeMethod
            && !restartReq |=> state == e1_fas_pkg::HOLDOFF;
    endproperty
    a_holdoffEntry: assert property (p_holdoffEntry) else $error("no hold-off");

    property p_holdoffExit;
        state == e1_fas_pkg::HOLDOFF && !frameLink.frameMark && !restartReq
            |=> state == e1_fas_pkg::HOLDOFF;
    endproperty
    a_holdoffExit: assert property (p_holdoffExit) else $error("hold-off ended early");

    property p_holdoffEnd;
        state == e1_fas_pkg::HOLDOFF && frameLink.frameMark |=> state == e1_fas_pkg::HUNT;
    endproperty
    a_holdoffEnd: assert property (p_holdoffEnd) else $error("hold-off did not end");

    property p_methodLatched;
        state != e1_fas_pkg::HUNT |=> $stable(activeMethod);
    endproperty
    a_methodLatched: assert property (p_methodLatched) else $error("method changed mid search");

    property p_irqLevel;
        |(irqStatus & irqEnable) |=> irq;
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("interrupt not raised");

    property p_irqQuiet;
        !(|(irqStatus & irqEnable)) |=> !irq;
    endproperty
    a_irqQuiet: assert property (p_irqQuiet) else $error("interrupt raised with nothing pending");

    property p_restart;
        restartReq |=> state == e1_fas_pkg::HUNT;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not return to step one");

    c_syncPlain: cover property (state == e1_fas_pkg::FAS_CHECK ##1 state == e1_fas_pkg::SYNCED);
    c_holdoff:   cover property (state == e1_fas_pkg::HOLDOFF ##1 state == e1_fas_pkg::HUNT);
    c_syncExtra: cover property (state == e1_fas_pkg::EXTRA_FAS ##1 state == e1_fas_pkg::SYNCED);
endmodule

// [sim/e1_line_source.sv]
// behavioural line interface that sends whole e1 frames to the framer
`timescale 1ns/1ps
module e1_line_source (
    // clock
    input  wire logic clk,
    // pacing: one bit each cycle, or one every second cycle
    input  wire logic slowRate,
    // receive stream towards the framer
    output logic      rxData,
    output logic      rxValid
);
    logic lastBit;

    initial begin
        rxData  = 1'b0;
        rxValid = 1'b0;
        lastBit = 1'b0;
    end

    // kind 0: alignment frame, 1: non-alignment frame, 2: non-alignment with bit 2 low
    // payload is all ones so the pattern never appears outside timeslot 0
    task automatic send_frame(input logic [1:0] kind);
        logic [7:0] ts0;
        ts0 = (kind == 2'h0) ? 8'h9b : ((kind == 2'h1) ? 8'hff : 8'hbf);
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            lastBit = (i < 8) ? ts0[7 - i] : 1'b1;
            rxData  <= lastBit;
            rxValid <= 1'b1;
            if (slowRate) begin
                @(posedge clk);
                // a bit no longer valid must not look like the one before
                rxData  <= ~lastBit;
                rxValid <= 1'b0;
            end
        end
        @(posedge clk);
        rxData  <= ~lastBit;
        rxValid <= 1'b0;
    endtask
endmodule

// [sim/test_e1_fas_alignment_search.sv]
// self-checking bench for the e1 alignment search
`timescale 1ns/1ps
module test_e1_fas_alignment_search;
    logic        clk;
    logic        rst_n;
    logic        rxData;
    logic        rxValid;
    logic        slowRate;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [11:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatIn;
    logic [31:0] wbDatOut;
    logic        wbAck;
    logic        frameSync;
    logic        irq;
    int          nFail;
    int          numChecks;

    e1_line_source line_u (.clk(clk), .slowRate(slowRate), .rxData(rxData), .rxValid(rxValid));

    e1_fas_alignment_search dut_u (
        .clk(clk), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
        .frameSync(frameSync), .irq(irq)
    );

    always #5 clk = ~clk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; request held until the edge that samples ack high, data taken there
    // a slave that never answers is left to the watchdog
    task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge clk);
        wbCyc   <= 1'b1;
        wbStb   <= 1'b1;
        wbWe    <= we;
        wbAdr   <= {idx, 2'b00};
        wbSel   <= 4'hf;
        wbDatIn <= wd;
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        wb(1'b1, idx, wd, rd);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, idx, 32'h0, rd);
        check(rd, exp);
    endtask

    // frames go out first entry first, two bits per entry
    task automatic send_seq(input int n, input logic [9:0] kinds);
        for (int i = 0; i < n; i++) line_u.send_frame(kinds[2*i +: 2]);
        repeat (3) @(posedge clk);
    endtask

    task automatic restart(input logic [31:0] ctrl);
        wr(e1_fas_pkg::CTRL_INDEX, ctrl | 32'h4);
        wr(e1_fas_pkg::IRQ_CLEAR_INDEX, 32'h3);
    endtask

    task automatic t_reset;
        check({31'h0, frameSync}, 32'h0);
        rdchk(e1_fas_pkg::CTRL_INDEX, 32'h0);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h0);
        rdchk(e1_fas_pkg::IRQ_EN_INDEX, 32'h0);
        rdchk(10'h3ff, 32'h0);
        $display("done reset values");
    endtask

    task automatic t_plain;
        slowRate <= 1'b1;
        restart(32'h0);
        wr(e1_fas_pkg::IRQ_EN_INDEX, 32'h1);
        send_seq(1, 10'h0);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h2);
        send_seq(1, 10'h1);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h4);
        check({31'h0, irq}, 32'h0);
        send_seq(1, 10'h0);
        check({31'h0, frameSync}, 32'h1);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'hd);
        check({31'h0, irq}, 32'h1);
        rdchk(e1_fas_pkg::IRQ_STAT_INDEX, 32'h1);
        wr(e1_fas_pkg::IRQ_CLEAR_INDEX, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(e1_fas_pkg::IRQ_EN_INDEX, 32'h0);
        slowRate <= 1'b0;
        $display("done plain search");
    endtask

    // the hold-off method parks in step four for one frame after a failed step two
    task automatic t_nfas_fail(input logic method);
        restart({31'h0, method});
        send_seq(2, 10'h8);
        rdchk(e1_fas_pkg::STATUS_INDEX, method ? 32'h6 : 32'h0);
        rdchk(e1_fas_pkg::IRQ_STAT_INDEX, 32'h2);
        send_seq(1, 10'h1);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h0);
        send_seq(3, 10'h04);
        check({31'h0, frameSync}, 32'h1);
        $display("done step two failure, method %0d", method);
    endtask

    task automatic t_fas_fail;
        restart(32'h1);
        send_seq(3, 10'h14);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h0);
        check({31'h0, frameSync}, 32'h0);
        $display("done step three failure");
    endtask

    task automatic t_extra;
        restart(32'h3);
        send_seq(3, 10'h04);
        check({31'h0, frameSync}, 32'h0);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'h8);
        send_seq(1, 10'h1);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'ha);
        send_seq(1, 10'h0);
        rdchk(e1_fas_pkg::STATUS_INDEX, 32'hd);
        $display("done extra frame check");
    endtask

    initial begin
        clk      = 1'b0;
        rst_n    = 1'b0;
        slowRate = 1'b0;
        wbCyc    = 1'b0;
        wbStb    = 1'b0;
        wbWe     = 1'b0;
        wbAdr    = 12'h0;
        wbSel    = 4'h0;
        wbDatIn  = 32'h0;
        nFail    = 0;
        numChecks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_plain();
        t_nfas_fail(1'b0);
        t_nfas_fail(1'b1);
        t_fas_fail();
        t_extra();
        tally_and_finish();
    end

    // the whole run needs about a seventh of this span
    initial begin
        #500000;
        nFail++;
        tally_and_finish();
    end
endmodule
